/* rsd_pkg.sv */
// rail sequence dependency package: constants, states and carriers
// Summary of operation
// - 32-bit on rail mask per rail; enable waits for their power good
// - 32-bit off rail mask per rail; enable stays until they drop good
// - leader fault with shutdown response shuts down masked followers
// - a retrying leader keeps followers running until retries run out
// - followers stop by the normal path, own off masks and off delay
// - a follower shut down by a leader never starts its own retries
// - follower latched off; turn-on ignored until a turn-off arrives
// - leader-latched reason bit set in follower's maker status word
// - in graceful shutdown, masked followers' undervoltage faults drop
// - 16-bit turn-on pin mask gates enable rise; ignored once enabled
// - 16-bit turn-off pin mask holds enable; ignored once disabled
// - one non-paged byte selects output pin; top three bits read zero
// - selector value n addresses physical output pin n plus one
`default_nettype none
package rsd_pkg;
  localparam int NRAIL = 32;
  localparam int NPIN  = 16;

  // command codes
  localparam logic [7:0] CMD_PIN_INDEX  = 8'hf7;
  localparam logic [7:0] CMD_ON_RAIL    = 8'he0;
  localparam logic [7:0] CMD_OFF_RAIL   = 8'he1;
  localparam logic [7:0] CMD_FOLLOWER   = 8'he2;
  localparam logic [7:0] CMD_ON_PIN     = 8'he3;
  localparam logic [7:0] CMD_OFF_PIN    = 8'he4;
  localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'he5;
  localparam logic [7:0] CMD_STATUS     = 8'he6;

  // field write strobes
  localparam int WR_ON_RAIL  = 0;
  localparam int WR_OFF_RAIL = 1;
  localparam int WR_FOLLOWER = 2;
  localparam int WR_ON_PIN   = 3;
  localparam int WR_OFF_PIN  = 4;
  localparam int WR_DELAY    = 5;
  localparam int NWR         = 6;

  // field layout and reset values
  localparam int INDEX_W      = 5;
  localparam int STAT_LATCH_B = 0;
  localparam logic [31:0] RST_RAIL_MASK = 32'h0000_0000;
  localparam logic [15:0] RST_PIN_MASK  = 16'h0000;
  localparam logic [7:0]  RST_DELAY     = 8'h00;
  localparam logic [INDEX_W-1:0] RST_INDEX = 5'h00;
  localparam logic [5:0]  PIN_OFFSET    = 6'h01;

  // timing: turn-off delay counts in milliseconds
  localparam int CLK_HZ      = 10_000_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  typedef enum logic [2:0] {
    RSD_OFF      = 3'b000,
    RSD_WAIT_ON  = 3'b001,
    RSD_ON       = 3'b010,
    RSD_WAIT_OFF = 3'b011,
    RSD_DELAY    = 3'b100
  } rsd_state_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [4:0]  page;
    logic [31:0] wdata;
  } rsd_cmd_s;

  typedef struct packed {
    logic [31:0] on_rail;
    logic [31:0] off_rail;
    logic [31:0] follower;
    logic [15:0] on_pin;
    logic [15:0] off_pin;
    logic [7:0]  turn_off_delay;
  } rsd_cfg_s;
endpackage
`default_nettype wire

/* rsd_sync.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module rsd_sync #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // meta_reg is read by sync_out only
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* rsd_rail.sv */
// one rail: dependency masks and enable sequencing state
`timescale 1ns/1ps
`default_nettype none
module rsd_rail (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  // configuration writes
  input  wire logic [rsd_pkg::NWR-1:0] cfg_we,
  input  wire logic [31:0]            cfg_wdata,
  // requests and conditions
  input  wire logic                   on_req,
  input  wire logic                   off_req,
  input  wire logic                   leader_kill,
  input  wire logic                   ms_tick,
  input  wire logic [31:0]            power_good,
  input  wire logic [15:0]            pin_state,
  // state
  output var  rsd_pkg::rsd_cfg_s      cfg,
  output var  logic                   enable_reg,
  output var  logic                   latched_reg
);
  rsd_pkg::rsd_state_e st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic       lat_next;
  logic       enable_next;
  wire logic  on_rail_met;
  wire logic  on_pin_met;
  wire logic  off_rail_met;
  wire logic  off_pin_met;
  wire logic  stop_req;

  // empty masks fall out as met
  assign on_rail_met  =
    (power_good & cfg.on_rail) == cfg.on_rail;
  assign on_pin_met   =
    (pin_state & cfg.on_pin) == cfg.on_pin;
  assign off_rail_met =
    (power_good & cfg.off_rail) == 32'h0000_0000;
  assign off_pin_met  = (pin_state & cfg.off_pin) == 16'h0000;
  assign stop_req     = off_req | leader_kill;

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      rsd_pkg::RSD_OFF: begin
        if (on_req && !latched_reg && !stop_req) begin
          st_next = rsd_pkg::RSD_WAIT_ON;
        end
      end
      rsd_pkg::RSD_WAIT_ON: begin
        if (stop_req) begin
          st_next = rsd_pkg::RSD_OFF;
        end else if (on_rail_met && on_pin_met) begin
          st_next = rsd_pkg::RSD_ON;
        end
      end
      rsd_pkg::RSD_ON: begin
        // pins no longer matter once enabled
        if (stop_req) begin
          st_next = rsd_pkg::RSD_WAIT_OFF;
        end
      end
      rsd_pkg::RSD_WAIT_OFF: begin
        if (off_rail_met && off_pin_met) begin
          st_next  = rsd_pkg::RSD_DELAY;
          cnt_next = cfg.turn_off_delay;
        end
      end
      rsd_pkg::RSD_DELAY: begin
        if (cnt_reg == 8'h00) begin
          st_next = rsd_pkg::RSD_OFF;
        end else if (ms_tick) begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: begin
        st_next = rsd_pkg::RSD_OFF;
      end
    endcase
  end

  // kill wins over a clearing off in the same cycle
  assign lat_next = leader_kill | (latched_reg & ~off_req);
  assign enable_next = (st_next == rsd_pkg::RSD_ON) ||
                       (st_next == rsd_pkg::RSD_WAIT_OFF) ||
                       (st_next == rsd_pkg::RSD_DELAY);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_reg      <= rsd_pkg::RSD_OFF;
      cnt_reg     <= rsd_pkg::RST_DELAY;
      latched_reg <= 1'b0;
      enable_reg  <= 1'b0;
    end else begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      latched_reg <= lat_next;
      enable_reg  <= enable_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfg <= {rsd_pkg::RST_RAIL_MASK, rsd_pkg::RST_RAIL_MASK,
              rsd_pkg::RST_RAIL_MASK, rsd_pkg::RST_PIN_MASK,
              rsd_pkg::RST_PIN_MASK, rsd_pkg::RST_DELAY};
    end else begin
      if (cfg_we[rsd_pkg::WR_ON_RAIL])  cfg.on_rail  <= cfg_wdata;
      if (cfg_we[rsd_pkg::WR_OFF_RAIL]) cfg.off_rail <= cfg_wdata;
      if (cfg_we[rsd_pkg::WR_FOLLOWER]) cfg.follower <= cfg_wdata;
      if (cfg_we[rsd_pkg::WR_ON_PIN])   cfg.on_pin   <= cfg_wdata[15:0];
      if (cfg_we[rsd_pkg::WR_OFF_PIN])  cfg.off_pin  <= cfg_wdata[15:0];
      if (cfg_we[rsd_pkg::WR_DELAY])    cfg.turn_off_delay <= cfg_wdata[7:0];
    end
  end

  sequence s_kill_while_on;
    (st_reg == rsd_pkg::RSD_ON) && leader_kill;
  endsequence

  sequence s_held_off;
    (st_reg == rsd_pkg::RSD_WAIT_OFF) && !(off_rail_met && off_pin_met);
  endsequence

  AST_ON_RAIL_GATE: assert property (@(posedge mclk)
    disable iff (!reset_n)
    $rose(enable_reg) |->
      (($past(power_good) & $past(cfg.on_rail)) == $past(cfg.on_rail)))
    else $error("enable rose before rail dependencies were met");

  AST_ON_PIN_GATE: assert property (@(posedge mclk)
    disable iff (!reset_n)
    $rose(enable_reg) |->
      (($past(pin_state) & $past(cfg.on_pin)) == $past(cfg.on_pin)))
    else $error("enable rose before pin dependencies were met");

  AST_OFF_HOLD: assert property (@(posedge mclk)
    disable iff (!reset_n)
    s_held_off |=> enable_reg && (st_reg == rsd_pkg::RSD_WAIT_OFF))
    else $error("enable dropped before off dependencies were met");

  AST_ON_STEADY: assert property (@(posedge mclk)
    disable iff (!reset_n)
    (st_reg == rsd_pkg::RSD_OFF) && !on_req |=> !enable_reg)
    else $error("disabled rail re-enabled without request");

  AST_KILL_PATH: assert property (@(posedge mclk)
    disable iff (!reset_n)
    s_kill_while_on |=> (st_reg == rsd_pkg::RSD_WAIT_OFF) && enable_reg)
    else $error("leader kill did not start the normal off path");

  AST_DELAY_END: assert property (@(posedge mclk)
    disable iff (!reset_n)
    (st_reg == rsd_pkg::RSD_DELAY) && (cnt_reg == 8'h00) |=> !enable_reg)
    else $error("turn-off delay did not end in off");

  AST_LATCH_HOLD: assert property (@(posedge mclk)
    disable iff (!reset_n)
    latched_reg && !off_req && (st_reg == rsd_pkg::RSD_OFF)
      |=> (st_reg == rsd_pkg::RSD_OFF) [*2])
    else $error("latched rail accepted a turn-on");

  AST_LATCH_SET: assert property (@(posedge mclk)
    disable iff (!reset_n)
    leader_kill |=> latched_reg)
    else $error("leader kill did not latch follower");

  AST_EMPTY_MASK: assert property (@(posedge mclk)
    disable iff (!reset_n)
    (st_reg == rsd_pkg::RSD_WAIT_ON) && (cfg.on_rail == 32'h0000_0000) &&
      (cfg.on_pin == 16'h0000) && !stop_req |=> enable_reg)
    else $error("empty on masks still held the rail");
endmodule
`default_nettype wire

/* rsd_top.sv */
// rail sequence dependency top: command port, fault followers, pin index
`timescale 1ns/1ps
`default_nettype none
module rsd_top #(
  parameter int TICK_CYCLES = rsd_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // command port
  input  wire rsd_pkg::rsd_cmd_s cmd,
  output logic [31:0]            rdata_reg,
  output logic                   rvalid_reg,
  output logic                   nack_reg,
  // power good from rail comparators, asynchronous
  input  wire logic [31:0]       power_good_pin,
  // same-clock inputs
  input  wire logic [15:0]       out_pin_state,
  input  wire logic [31:0]       on_req,
  input  wire logic [31:0]       off_req,
  input  wire logic [31:0]       fault_shutdown,
  input  wire logic [31:0]       retries_left,
  input  wire logic [31:0]       graceful_active,
  input  wire logic [31:0]       uv_fault_in,
  // outputs
  output logic [31:0]            rail_enable_reg,
  output logic [31:0]            retry_inhibit_reg,
  output logic [31:0]            uv_fault_act_reg,
  output logic [5:0]             pin_number_reg
);
  logic [31:0]                 power_good;
  logic [31:0]                 rail_en;
  logic [31:0]                 rail_lat;
  logic [31:0]                 leader_kill;
  logic [31:0]                 uv_suppress;
  rsd_pkg::rsd_cfg_s           cfg_arr [rsd_pkg::NRAIL];
  logic [rsd_pkg::INDEX_W-1:0] index_reg;
  logic [13:0]                 tick_cnt_reg;
  logic                        ms_tick_reg;
  logic [31:0]                 rd_word;
  wire logic                   code_known;
  wire logic                   wr_cmd;
  wire logic                   rd_cmd;
  wire logic [rsd_pkg::NWR-1:0] field_we;
  wire logic [31:0]            trigger;
  wire rsd_pkg::rsd_cfg_s      sel_cfg;
  wire logic [31:0]            status_word;

  rsd_sync #(
    .W (32)
  ) u_pg_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (power_good_pin),
    .sync_out (power_good)
  );

  assign wr_cmd  = cmd.valid & cmd.write;
  assign rd_cmd  = cmd.valid & ~cmd.write;
  assign sel_cfg = cfg_arr[cmd.page];
  assign status_word =
    32'(rail_lat[cmd.page]) << rsd_pkg::STAT_LATCH_B;

  // a leader still holding retries does not pass its fault on
  assign trigger = fault_shutdown & ~retries_left;

  assign field_we[rsd_pkg::WR_ON_RAIL]  =
    wr_cmd && (cmd.code == rsd_pkg::CMD_ON_RAIL);
  assign field_we[rsd_pkg::WR_OFF_RAIL] =
    wr_cmd && (cmd.code == rsd_pkg::CMD_OFF_RAIL);
  assign field_we[rsd_pkg::WR_FOLLOWER] =
    wr_cmd && (cmd.code == rsd_pkg::CMD_FOLLOWER);
  assign field_we[rsd_pkg::WR_ON_PIN]   =
    wr_cmd && (cmd.code == rsd_pkg::CMD_ON_PIN);
  assign field_we[rsd_pkg::WR_OFF_PIN]  =
    wr_cmd && (cmd.code == rsd_pkg::CMD_OFF_PIN);
  assign field_we[rsd_pkg::WR_DELAY]    =
    wr_cmd && (cmd.code == rsd_pkg::CMD_TURN_OFF_DELAY);

  assign code_known = (cmd.code == rsd_pkg::CMD_PIN_INDEX)  ||
                      (cmd.code == rsd_pkg::CMD_ON_RAIL)    ||
                      (cmd.code == rsd_pkg::CMD_OFF_RAIL)   ||
                      (cmd.code == rsd_pkg::CMD_FOLLOWER)   ||
                      (cmd.code == rsd_pkg::CMD_ON_PIN)     ||
                      (cmd.code == rsd_pkg::CMD_OFF_PIN)    ||
                      (cmd.code == rsd_pkg::CMD_TURN_OFF_DELAY) ||
                      ((cmd.code == rsd_pkg::CMD_STATUS) && !cmd.write);

  always_comb begin
    if (cmd.code == rsd_pkg::CMD_PIN_INDEX) begin
      rd_word = {27'h000_0000, index_reg};
    end else if (cmd.code == rsd_pkg::CMD_ON_RAIL) begin
      rd_word = sel_cfg.on_rail;
    end else if (cmd.code == rsd_pkg::CMD_OFF_RAIL) begin
      rd_word = sel_cfg.off_rail;
    end else if (cmd.code == rsd_pkg::CMD_FOLLOWER) begin
      rd_word = sel_cfg.follower;
    end else if (cmd.code == rsd_pkg::CMD_ON_PIN) begin
      rd_word = {16'h0000, sel_cfg.on_pin};
    end else if (cmd.code == rsd_pkg::CMD_OFF_PIN) begin
      rd_word = {16'h0000, sel_cfg.off_pin};
    end else if (cmd.code == rsd_pkg::CMD_TURN_OFF_DELAY) begin
      rd_word = {24'h00_0000, sel_cfg.turn_off_delay};
    end else if (cmd.code == rsd_pkg::CMD_STATUS) begin
      rd_word = status_word;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // follower kill and graceful suppress fan out over every leader
  always_comb begin
    leader_kill = 32'h0000_0000;
    uv_suppress = 32'h0000_0000;
    for (int j = 0; j < rsd_pkg::NRAIL; j++) begin
      leader_kill = leader_kill |
                    ({32{trigger[j]}} & cfg_arr[j].follower);
      uv_suppress = uv_suppress |
                    ({32{graceful_active[j]}} & cfg_arr[j].follower);
    end
  end

  for (genvar i = 0; i < rsd_pkg::NRAIL; i++) begin : g_rail
    rsd_rail u_rail (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .cfg_we      (field_we & {rsd_pkg::NWR{cmd.page == 5'(i)}}),
      .cfg_wdata   (cmd.wdata),
      .on_req      (on_req[i]),
      .off_req     (off_req[i]),
      .leader_kill (leader_kill[i]),
      .ms_tick     (ms_tick_reg),
      .power_good  (power_good),
      .pin_state   (out_pin_state),
      .cfg         (cfg_arr[i]),
      .enable_reg  (rail_en[i]),
      .latched_reg (rail_lat[i])
    );
  end

  // millisecond tick for the turn-off delay
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tick_cnt_reg <= 14'h0000;
      ms_tick_reg  <= 1'b0;
    end else if (tick_cnt_reg == 14'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 14'h0000;
      ms_tick_reg  <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 14'h0001;
      ms_tick_reg  <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      index_reg      <= rsd_pkg::RST_INDEX;
      pin_number_reg <= rsd_pkg::PIN_OFFSET;
    end else begin
      if (wr_cmd && (cmd.code == rsd_pkg::CMD_PIN_INDEX)) begin
        index_reg <= cmd.wdata[rsd_pkg::INDEX_W-1:0];
      end
      pin_number_reg <= {1'b0, index_reg} + rsd_pkg::PIN_OFFSET;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      nack_reg   <= 1'b0;
    end else begin
      rdata_reg  <= (rd_cmd && code_known) ? rd_word : 32'h0000_0000;
      rvalid_reg <= rd_cmd && code_known;
      nack_reg   <= cmd.valid && !code_known;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rail_enable_reg   <= 32'h0000_0000;
      retry_inhibit_reg <= 32'h0000_0000;
      uv_fault_act_reg  <= 32'h0000_0000;
    end else begin
      rail_enable_reg   <= rail_en;
      retry_inhibit_reg <= rail_lat;
      uv_fault_act_reg  <= uv_fault_in & ~uv_suppress;
    end
  end

  AST_INDEX_ZERO_TOP: assert property (@(posedge mclk)
    disable iff (!reset_n)
    rd_cmd && (cmd.code == rsd_pkg::CMD_PIN_INDEX)
      |=> rdata_reg[7:5] == 3'b000)
    else $error("selector top bits read non-zero");

  AST_PIN_MAP: assert property (@(posedge mclk)
    disable iff (!reset_n)
    wr_cmd && (cmd.code == rsd_pkg::CMD_PIN_INDEX)
      |=> ##1 pin_number_reg == ({1'b0, $past(cmd.wdata[4:0], 2)} + 6'h01))
    else $error("selected pin is not index plus one");

  AST_RETRY_HOLD: assert property (@(posedge mclk)
    disable iff (!reset_n)
    (fault_shutdown & retries_left) == fault_shutdown
      |-> leader_kill == 32'h0000_0000)
    else $error("retrying leader shut down followers");

  AST_NO_RETRY: assert property (@(posedge mclk)
    disable iff (!reset_n)
    (leader_kill != 32'h0000_0000)
      |=> ##1 (retry_inhibit_reg & $past(leader_kill, 2)) ==
        $past(leader_kill, 2))
    else $error("follower not inhibited from retry");

  AST_UV_DROP: assert property (@(posedge mclk)
    disable iff (!reset_n)
    1'b1 |=> (uv_fault_act_reg & $past(uv_suppress)) == 32'h0000_0000)
    else $error("suppressed undervoltage fault passed");
endmodule
`default_nettype wire

/* rsd_dummy_guard.sv */
// intentionally empty compilation unit
`default_nettype none
`default_nettype wire

/* rsd_rail_model.sv */
// rail power stage model: power good follows enable after a ramp
`timescale 1ns/1ps
`default_nettype none
module rsd_rail_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // rail side
  input  wire logic [31:0] rail_enable,
  output var  logic [31:0] power_good_pin
);
  logic [31:0] ramp1_reg;
  logic [31:0] ramp2_reg;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ramp1_reg <= 32'h0000_0000;
      ramp2_reg <= 32'h0000_0000;
    end else begin
      ramp1_reg <= rail_enable;
      ramp2_reg <= ramp1_reg;
    end
  end

  // a disabled rail collapses at once, so good drops with enable
  assign power_good_pin = ramp2_reg & rail_enable;
endmodule
`default_nettype wire

/* rail_sequence_dependency_logic_test.sv */
// self-checking bench for the rail sequence dependency top
`timescale 1ns/1ps
`default_nettype none
module rail_sequence_dependency_logic_test;
  localparam int TICKS = 4;
  localparam logic [7:0] CODES [6] = '{rsd_pkg::CMD_ON_RAIL,
    rsd_pkg::CMD_OFF_RAIL, rsd_pkg::CMD_FOLLOWER, rsd_pkg::CMD_ON_PIN,
    rsd_pkg::CMD_OFF_PIN, rsd_pkg::CMD_TURN_OFF_DELAY};
  localparam logic [31:0] WMASK [6] = '{32'hffff_ffff, 32'hffff_ffff,
    32'hffff_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_00ff};

  logic              mclk = 1'b0;
  logic              reset_n;
  rsd_pkg::rsd_cmd_s cmd;
  logic [31:0]       rdata_reg;
  logic              rvalid_reg;
  logic              nack_reg;
  logic [31:0]       power_good_pin;
  logic [15:0]       out_pin_state;
  logic [31:0]       on_req;
  logic [31:0]       off_req;
  logic [31:0]       fault_shutdown;
  logic [31:0]       retries_left;
  logic [31:0]       graceful_active;
  logic [31:0]       uv_fault_in;
  logic [31:0]       rail_enable_reg;
  logic [31:0]       retry_inhibit_reg;
  logic [31:0]       uv_fault_act_reg;
  logic [5:0]        pin_number_reg;
  int                err_total = 0;
  int                n_compared = 0;
  integer            seed = 45276;
  logic [32:0]       exp_q [$];
  logic [4:0]        pg;
  logic [4:0]        first_pg;
  logic [31:0]       val;

  rsd_top #(.TICK_CYCLES(TICKS)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .cmd(cmd), .rdata_reg(rdata_reg),
    .rvalid_reg(rvalid_reg), .nack_reg(nack_reg),
    .power_good_pin(power_good_pin), .out_pin_state(out_pin_state),
    .on_req(on_req), .off_req(off_req), .fault_shutdown(fault_shutdown),
    .retries_left(retries_left), .graceful_active(graceful_active),
    .uv_fault_in(uv_fault_in), .rail_enable_reg(rail_enable_reg),
    .retry_inhibit_reg(retry_inhibit_reg),
    .uv_fault_act_reg(uv_fault_act_reg), .pin_number_reg(pin_number_reg));

  rsd_rail_model i_rails (
    .mclk(mclk), .reset_n(reset_n), .rail_enable(rail_enable_reg),
    .power_good_pin(power_good_pin));

  always #50 mclk = ~mclk;

  task automatic check(input string what, input logic [32:0] seen,
                       input logic [32:0] exp_v);
    n_compared++;
    if (seen !== exp_v) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp_v, seen);
    end
  endtask

  task automatic give_verdict;
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // valid is left high so commands can run back to back; idle ends them
  task automatic send(input logic wr, input logic [7:0] code,
                      input logic [4:0] page, input logic [31:0] data);
    cmd <= '{valid: 1'b1, write: wr, code: code, page: page, wdata: data};
    @(negedge mclk);
  endtask

  task automatic idle;
    cmd.valid <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic rd(input logic [7:0] code, input logic [4:0] page,
                    input logic [31:0] exp_v);
    exp_q.push_back({1'b0, exp_v});
    send(1'b0, code, page, 32'h0000_0000);
    idle();
  endtask

  task automatic refused(input logic wr, input logic [7:0] code);
    exp_q.push_back({1'b1, 32'h0000_0000});
    send(wr, code, 5'h00, 32'h0000_0001);
    idle();
  endtask

  task automatic pulse(input int kind, input int r);
    if (kind == 0) on_req[r] <= 1'b1;
    else if (kind == 1) off_req[r] <= 1'b1;
    else fault_shutdown[r] <= 1'b1;
    @(negedge mclk);
    on_req <= 32'h0000_0000;
    off_req <= 32'h0000_0000;
    fault_shutdown <= 32'h0000_0000;
  endtask

  task automatic stay_en(input int r, input logic v, input int cyc);
    repeat (cyc) begin
      @(negedge mclk);
      check("rail enable", rail_enable_reg[r], v);
    end
  endtask

  task automatic reach_en(input int r, input logic v, input int lim);
    int n;
    n = 0;
    while (rail_enable_reg[r] !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    check("rail enable", rail_enable_reg[r], v);
  endtask

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (10) @(negedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
  endtask

  // answers come one cycle after the command, so notes stay in order
  always @(negedge mclk) begin
    if (rvalid_reg === 1'b1 || nack_reg === 1'b1) begin
      if (exp_q.size() == 0) check("spare answer", 1'b1, 1'b0);
      else check("answer", {nack_reg, rdata_reg}, exp_q.pop_front());
    end
  end

  initial begin
    #400_000;
    err_total++;
    give_verdict();
  end

  initial begin
    reset_n = 1'b0;
    cmd = '0;
    out_pin_state = 16'h0000;
    on_req = 32'h0000_0000;
    off_req = 32'h0000_0000;
    fault_shutdown = 32'h0000_0000;
    retries_left = 32'h0000_0000;
    graceful_active = 32'h0000_0000;
    uv_fault_in = 32'h0000_0000;
    @(negedge mclk);
    do_reset();
    check("pin number", pin_number_reg, 6'h01);
    for (int k = 0; k < 6; k++) begin
      pg = 5'($random(seed));
      val = $random(seed);
      if (k == 0) first_pg = pg;
      send(1'b1, CODES[k], pg, val);
      rd(CODES[k], pg, val & WMASK[k]);
    end
    send(1'b1, rsd_pkg::CMD_PIN_INDEX, 5'h1f, 32'h0000_00ff);
    rd(rsd_pkg::CMD_PIN_INDEX, 5'h03, 32'h0000_001f);
    refused(1'b1, 8'h00);
    refused(1'b1, rsd_pkg::CMD_STATUS);
    foreach (CODES[k]) begin
      send(1'b1, rsd_pkg::CMD_PIN_INDEX, 5'h00, 32'(k * 3));
      idle();
      check("pin number", pin_number_reg, 6'(k * 3 + 1));
    end
    do_reset();
    rd(rsd_pkg::CMD_ON_RAIL, first_pg, 32'h0000_0000);
    send(1'b1, rsd_pkg::CMD_ON_RAIL, 5'h02, 32'h0000_0002);
    send(1'b1, rsd_pkg::CMD_ON_PIN, 5'h03, 32'h0000_0010);
    send(1'b1, rsd_pkg::CMD_OFF_PIN, 5'h03, 32'h0000_0010);
    send(1'b1, rsd_pkg::CMD_OFF_RAIL, 5'h01, 32'h0000_0004);
    send(1'b1, rsd_pkg::CMD_FOLLOWER, 5'h04, 32'h0000_0001);
    send(1'b1, rsd_pkg::CMD_TURN_OFF_DELAY, 5'h00, 32'h0000_0001);
    idle();
    pulse(0, 0);
    reach_en(0, 1'b1, 4);
    pulse(0, 2);
    stay_en(2, 1'b0, 12);
    pulse(0, 1);
    reach_en(1, 1'b1, 6);
    reach_en(2, 1'b1, 15);
    out_pin_state <= 16'hffef;
    pulse(0, 3);
    stay_en(3, 1'b0, 10);
    out_pin_state <= 16'hffff;
    reach_en(3, 1'b1, 6);
    out_pin_state <= 16'h0000;
    stay_en(3, 1'b1, 8);
    out_pin_state <= 16'h0010;
    pulse(1, 3);
    stay_en(3, 1'b1, 10);
    out_pin_state <= 16'h0000;
    reach_en(3, 1'b0, 8);
    out_pin_state <= 16'h0010;
    stay_en(3, 1'b0, 6);
    pulse(1, 1);
    stay_en(1, 1'b1, 12);
    pulse(1, 2);
    reach_en(2, 1'b0, 8);
    reach_en(1, 1'b0, 12);
    retries_left <= 32'h0000_0010;
    pulse(2, 4);
    stay_en(0, 1'b1, 15);
    check("retry inhibit", retry_inhibit_reg[0], 1'b0);
    retries_left <= 32'h0000_0000;
    pulse(2, 4);
    stay_en(0, 1'b1, 3);
    reach_en(0, 1'b0, 20);
    check("retry inhibit", retry_inhibit_reg[0], 1'b1);
    rd(rsd_pkg::CMD_STATUS, 5'h00, 32'h0000_0001);
    pulse(0, 0);
    stay_en(0, 1'b0, 10);
    pulse(1, 0);
    rd(rsd_pkg::CMD_STATUS, 5'h00, 32'h0000_0000);
    pulse(0, 0);
    reach_en(0, 1'b1, 6);
    val = $random(seed) | 32'h0000_0001;
    graceful_active <= 32'h0000_0010;
    uv_fault_in <= val;
    @(negedge mclk);
    check("uv fault", uv_fault_act_reg, val & 32'hffff_fffe);
    graceful_active <= 32'h0000_0000;
    @(negedge mclk);
    check("uv fault", uv_fault_act_reg, val);
    check("answers left", exp_q.size(), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
